// ---- shared/su_pkg.sv ----
/*
  Constants of the serial port: register map, field positions, reset
  values, divider limits and frame lengths.
  Assumes hclk is the oscillator clock of the port.
*/
package su_pkg;
  // Register byte offsets
  localparam logic [7:0] SU_OFS_CTRL = 8'h00;
  localparam logic [7:0] SU_OFS_TXDATA = 8'h04;
  localparam logic [7:0] SU_OFS_RXDATA = 8'h08;
  localparam logic [7:0] SU_OFS_STATUS = 8'h0c;
  localparam logic [7:0] SU_OFS_INT_CLR = 8'h10;
  localparam logic [7:0] SU_OFS_INT_EN = 8'h14;
  // Control register fields
  localparam int SU_CTRL_MODE_LOW = 0;
  localparam int SU_CTRL_MODE_HIGH = 1;
  localparam int SU_CTRL_BAUD_SRC = 2;
  localparam int SU_CTRL_BAUD_DBL = 3;
  localparam int SU_CTRL_RX_EN = 4;
  localparam int SU_CTRL_TX_BIT8 = 5;
  localparam int SU_CTRL_W = 6;
  localparam logic [5:0] SU_CTRL_RESET = 6'h00;
  // Status / clear / enable fields
  localparam int SU_ST_RX_DONE = 0;
  localparam int SU_ST_TX_DONE = 1;
  localparam int SU_ST_TX_BUSY = 2;
  localparam int SU_ST_RX_BUSY = 3;
  localparam int SU_IRQ_W = 2;
  localparam logic [1:0] SU_IRQ_EN_RESET = 2'h0;
  // Baud tick limits (divisor minus one) for the 16x baud clock
  localparam logic [7:0] SU_LIM_M2_X1 = 8'h03;
  localparam logic [7:0] SU_LIM_M2_X2 = 8'h01;
  localparam logic [7:0] SU_LIM_SYS_X1 = 8'h9b;
  localparam logic [7:0] SU_LIM_SYS_X2 = 8'h4d;
  localparam logic [7:0] SU_LIM_T1_X1 = 8'h01;
  localparam logic [7:0] SU_LIM_T1_X2 = 8'h00;
  // Sub-bit counters
  localparam logic [3:0] SU_SUB_ASYNC_LAST = 4'hf;
  localparam logic [3:0] SU_SUB_SHIFT_LAST = 4'hb;
  localparam logic [3:0] SU_SUB_SHIFT_HALF = 4'h6;
  localparam logic [3:0] SU_SUB_SAMPLE = 4'h7;
  // Frame lengths in bits
  localparam logic [3:0] SU_BITS_SHIFT = 4'h8;
  localparam logic [3:0] SU_BITS_UART8 = 4'ha;
  localparam logic [3:0] SU_BITS_UART9 = 4'hb;
  localparam logic [3:0] SU_RXBITS_UART8 = 4'h9;
  localparam logic [3:0] SU_RXBITS_UART9 = 4'ha;
  // AHB transfer type
  localparam logic [1:0] SU_HTRANS_NONSEQ = 2'h2;
  // Engine states
  typedef enum logic [1:0] {
    SU_TX_IDLE = 2'b01,
    SU_TX_SHIFT = 2'b10
  } su_tx_state_type;
  typedef enum logic [2:0] {
    SU_RX_IDLE = 3'b001,
    SU_RX_START = 3'b010,
    SU_RX_DATA = 3'b100
  } su_rx_state_type;
endpackage

// ---- verilog/su_serial_port.sv ----
/*
  Serial port with half-duplex shift-register mode, three full-duplex UART modes,
  baud generation and an AHB-Lite register slave with interrupt.
  Assumes one master, single word transfers, synchronous pin inputs
  and a one-cycle timer 1 overflow pulse on t1_ovf.
*/
// Behaviour
// - Transmit and receive run at once in modes 1-3; four modes, one synchronous.
// - Mode 0: shift register, data on rxd, txd clocks, 8 bits LSB first.
// - Mode 1: 8-bit UART, variable rate, 10-bit frames.
// - Mode 2: 9-bit UART, 11 bits, osc/64 or osc/32 by baud_double.
// - Mode 3: like mode 2 but variable baud rate.
// - Mode 0 shifts at osc/12 regardless of rate bits.
// - Async modes use 16x baud clock divided by 16 per bit.
// - Variable modes take rate from timer 1 or system divider.
// - Source 0: rate is 2^double times timer 1 overflow rate over 32.
// - Source 1: rate is 2^double times osc over 2496.
module su_serial_port (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic t1_ovf,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic irq
);
  import su_pkg::*;

  logic [SU_CTRL_W-1:0] ctrl_q;
  logic [1:0] int_en_q;
  logic rx_done_flag_q, tx_done_flag_q;
  logic [8:0] rx_buf_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] brg_q;
  su_tx_state_type tx_state_q, tx_state_d;
  logic [10:0] tx_sh_q, tx_sh_d;
  logic [3:0] tx_bits_q, tx_bits_d, tx_sub_q, tx_sub_d;
  su_rx_state_type rx_state_q, rx_state_d;
  logic [9:0] rx_sh_q, rx_sh_d;
  logic [3:0] rx_bits_q, rx_bits_d, rx_sub_q, rx_sub_d;

  // Control fields
  wire mode_select_low = ctrl_q[SU_CTRL_MODE_LOW];
  wire mode_select_high = ctrl_q[SU_CTRL_MODE_HIGH];
  wire baud_source_select = ctrl_q[SU_CTRL_BAUD_SRC];
  wire baud_double = ctrl_q[SU_CTRL_BAUD_DBL];
  wire rx_enable = ctrl_q[SU_CTRL_RX_EN];
  wire mode_shift = !mode_select_high && !mode_select_low;
  wire mode_fixed9 = mode_select_high && !mode_select_low;
  wire nine_bit = mode_select_high;

  // Bus decode
  wire addr_phase = hsel && hready && htrans == SU_HTRANS_NONSEQ;
  wire rd_req = addr_phase && !hwrite;
  wire wr_now = wr_pend_q;
  wire wr_ctrl = wr_now && wr_addr_q == SU_OFS_CTRL;
  wire wr_tx = wr_now && wr_addr_q == SU_OFS_TXDATA;
  wire wr_clr = wr_now && wr_addr_q == SU_OFS_INT_CLR;
  wire wr_en = wr_now && wr_addr_q == SU_OFS_INT_EN;

  // Sub-bit counter limit per mode
  function automatic logic [3:0] sub_last(input logic shift_mode);
    return shift_mode ? SU_SUB_SHIFT_LAST : SU_SUB_ASYNC_LAST;
  endfunction

  // Baud clock generator, 16x the bit rate
  wire use_t1 = !mode_fixed9 && !baud_source_select;
  wire brg_step = use_t1 ? t1_ovf : 1'b1;
  wire [7:0] lim_m2 = baud_double ? SU_LIM_M2_X2 : SU_LIM_M2_X1;
  wire [7:0] lim_t1 = baud_double ? SU_LIM_T1_X2 : SU_LIM_T1_X1;
  wire [7:0] lim_sys = baud_double ? SU_LIM_SYS_X2 : SU_LIM_SYS_X1;
  wire [7:0] brg_lim = mode_fixed9 ? lim_m2 :
                       (use_t1 ? lim_t1 : lim_sys);
  wire baud_tick = brg_step && brg_q >= brg_lim;
  wire [7:0] brg_d = !brg_step ? brg_q :
                     (baud_tick ? 8'h00 : brg_q + 8'h01);
  // Shift mode steps every oscillator cycle, 12 per bit
  wire eng_tick = mode_shift ? 1'b1 : baud_tick;
  wire [3:0] last_sub = sub_last(mode_shift);

  // Transmit engine
  wire tx_busy = tx_state_q == SU_TX_SHIFT;
  wire tx_start = wr_tx && !tx_busy;
  wire tx_bit_end = eng_tick && tx_sub_q == last_sub;
  wire tx_last = tx_bit_end && tx_bits_q == 4'h1;
  wire tx_bit8 = nine_bit ? ctrl_q[SU_CTRL_TX_BIT8] : 1'b1;
  wire [10:0] tx_frame = mode_shift ? {3'h0, hwdata[7:0]} :
                         {1'b1, tx_bit8, hwdata[7:0], 1'b0};
  wire [3:0] tx_len = mode_shift ? SU_BITS_SHIFT :
                      (nine_bit ? SU_BITS_UART9 : SU_BITS_UART8);

  always_comb begin
    tx_state_d = tx_state_q;
    tx_sh_d = tx_sh_q;
    tx_bits_d = tx_bits_q;
    tx_sub_d = tx_sub_q;
    unique case (tx_state_q)
      SU_TX_IDLE: begin
        if (tx_start) begin
          tx_state_d = SU_TX_SHIFT;
          tx_sh_d = tx_frame;
          tx_bits_d = tx_len;
          tx_sub_d = 4'h0;
        end
      end
      SU_TX_SHIFT: begin
        if (eng_tick) begin
          tx_sub_d = tx_bit_end ? 4'h0 : tx_sub_q + 4'h1;
        end
        if (tx_bit_end) begin
          tx_sh_d = {1'b1, tx_sh_q[10:1]};
          tx_bits_d = tx_bits_q - 4'h1;
        end
        if (tx_last) begin
          tx_state_d = SU_TX_IDLE;
        end
      end
    endcase
  end

  // Receive engine
  wire rx_busy = rx_state_q != SU_RX_IDLE;
  wire rx_go_shift = mode_shift && rx_enable && !rx_done_flag_q &&
                     !tx_busy && !tx_start;
  wire rx_go_async = !mode_shift && rx_enable && baud_tick && !rxd_in;
  wire rx_sample = eng_tick && rx_sub_q == (mode_shift ?
                   SU_SUB_SHIFT_HALF : SU_SUB_SAMPLE);
  wire rx_bit_end = eng_tick && rx_sub_q == last_sub;
  wire [3:0] rx_len = mode_shift ? SU_BITS_SHIFT :
                      (nine_bit ? SU_RXBITS_UART9 : SU_RXBITS_UART8);
  wire rx_store = rx_state_q == SU_RX_DATA && rx_sample &&
                  rx_bits_q == 4'h1;
  wire [9:0] rx_sh_in = {rxd_in, rx_sh_q[9:1]};
  wire [8:0] rx_word = mode_shift ? {1'b0, rx_sh_in[9:2]} :
                       (nine_bit ? rx_sh_in[8:0] :
                        {rx_sh_in[9], rx_sh_in[8:1]});

  always_comb begin
    rx_state_d = rx_state_q;
    rx_sh_d = rx_sh_q;
    rx_bits_d = rx_bits_q;
    rx_sub_d = rx_sub_q;
    if (rx_busy && eng_tick) begin
      rx_sub_d = rx_bit_end ? 4'h0 : rx_sub_q + 4'h1;
    end
    unique case (rx_state_q)
      SU_RX_IDLE: begin
        rx_sub_d = 4'h0;
        rx_bits_d = rx_len;
        if (rx_go_shift) begin
          rx_state_d = SU_RX_DATA;
        end else if (rx_go_async) begin
          rx_state_d = SU_RX_START;
        end
      end
      SU_RX_START: begin
        if (rx_sample) begin
          rx_state_d = rxd_in ? SU_RX_IDLE : SU_RX_DATA;
        end
      end
      SU_RX_DATA: begin
        if (rx_sample) begin
          rx_sh_d = rx_sh_in;
          rx_bits_d = rx_bits_q - 4'h1;
        end
        if (rx_store) begin
          rx_state_d = SU_RX_IDLE;
        end
      end
    endcase
  end

  // Pins: mode 0 drives rxd with data only while transmitting, and txd with the shift clock
  wire shift_clk_lo = tx_busy ? tx_sub_q < SU_SUB_SHIFT_HALF :
                      rx_busy && rx_sub_q < SU_SUB_SHIFT_HALF;
  wire txd_d = mode_shift ? !shift_clk_lo :
               (tx_busy ? tx_sh_q[0] : 1'b1);
  wire rxd_oe_d = mode_shift && tx_busy;
  wire rxd_out_d = rxd_oe_d ? tx_sh_q[0] : 1'b1;

  // Flags: hardware set wins over software clear
  wire [1:0] clr_bits = wr_clr ? hwdata[SU_IRQ_W-1:0] : 2'h0;
  wire rx_done_d = (rx_done_flag_q && !clr_bits[SU_ST_RX_DONE]) ||
                   rx_store;
  wire tx_done_d = (tx_done_flag_q && !clr_bits[SU_ST_TX_DONE]) ||
                   tx_last;
  wire [1:0] status_flags = {tx_done_flag_q, rx_done_flag_q};
  wire irq_d = |(status_flags & int_en_q);

  // Read mux, captured in the address phase
  wire [31:0] rd_mux =
    haddr == SU_OFS_CTRL ? {26'h0, ctrl_q} :
    haddr == SU_OFS_RXDATA ? {23'h0, rx_buf_q} :
    haddr == SU_OFS_STATUS ? {28'h0, rx_busy, tx_busy, status_flags} :
    haddr == SU_OFS_INT_EN ? {30'h0, int_en_q} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h0;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr;
      hrdata_q <= rd_req ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= SU_CTRL_RESET;
      int_en_q <= SU_IRQ_EN_RESET;
      rx_done_flag_q <= 1'b0;
      tx_done_flag_q <= 1'b0;
      rx_buf_q <= 9'h0;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= hwdata[SU_CTRL_W-1:0];
      if (wr_en) int_en_q <= hwdata[SU_IRQ_W-1:0];
      if (rx_store) rx_buf_q <= rx_word;
      rx_done_flag_q <= rx_done_d;
      tx_done_flag_q <= tx_done_d;
      irq <= irq_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brg_q <= 8'h00;
      tx_state_q <= SU_TX_IDLE;
      tx_sh_q <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_sub_q <= 4'h0;
      rx_state_q <= SU_RX_IDLE;
      rx_sh_q <= 10'h0;
      rx_bits_q <= 4'h0;
      rx_sub_q <= 4'h0;
    end else begin
      brg_q <= brg_d;
      tx_state_q <= tx_state_d;
      tx_sh_q <= tx_sh_d;
      tx_bits_q <= tx_bits_d;
      tx_sub_q <= tx_sub_d;
      rx_state_q <= rx_state_d;
      rx_sh_q <= rx_sh_d;
      rx_bits_q <= rx_bits_d;
      rx_sub_q <= rx_sub_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
    end else begin
      txd_out <= txd_d;
      rxd_out <= rxd_out_d;
      rxd_oe <= rxd_oe_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
endmodule // su_serial_port

// ---- sim/su_serial_port_checker.sv ----
/*
  Port checker of the serial port: bus answer, shift mode pin timing.
  Assumes it is bound to su_serial_port with one clock domain.
*/
module su_serial_port_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out
);
  import su_pkg::*;
  logic [7:0] oe_cnt_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles the data pin has been driven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      oe_cnt_q <= 8'h00;
    else
      oe_cnt_q <= rxd_oe ? oe_cnt_q + 8'h01 : 8'h00;
  end
  sequence s_clk_low;
    !txd_out [*6];
  endsequence
  sequence s_clk_high;
    txd_out [*6];
  endsequence
  AST_READY: assert property (hreadyout)
    else $error("hreadyout low");
  AST_OKAY: assert property (!hresp)
    else $error("hresp not okay");
  AST_RD_IDLE: assert property (
    !$past(hsel && hready && htrans == SU_HTRANS_NONSEQ && !hwrite)
    |-> hrdata == 32'h0) else $error("hrdata not zero");
  AST_RD_HIGH: assert property (hrdata[31:9] == 23'h0)
    else $error("hrdata upper bits set");
  AST_SHIFT_CLK: assert property (
    rxd_oe && $fell(txd_out) |-> s_clk_low ##1 s_clk_high)
    else $error("shift clock shape wrong");
  AST_SHIFT_DATA: assert property (
    rxd_oe && $past(rxd_oe) && txd_out && $past(txd_out)
    |-> $stable(rxd_out)) else $error("data moved with clock high");
  AST_PIN_REL: assert property (!rxd_oe |-> rxd_out)
    else $error("released data pin not high");
  AST_SHIFT_LEN: assert property (
    $fell(rxd_oe) |-> oe_cnt_q inside {[8'h5e:8'h62]})
    else $error("shift frame length wrong");
endmodule // su_serial_port_checker

bind su_serial_port su_serial_port_checker CHK (.hclk, .hresetn,
  .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
  .rxd_out, .rxd_oe, .txd_out);

// ---- sim/su_remote_model.sv ----
/*
  Remote serial device: sends asynchronous frames and shift-mode bytes
  on the receive pin.
  Assumes send is called just after a rising clock edge and shift_in
  before the port starts its shift clock on txd_out.
*/
module su_remote_model (
  input wire logic hclk,
  input wire logic rxd_oe,
  input wire logic rxd_out,
  input wire logic txd_out,
  output logic rxd_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b1;
  // Port drive wins while it owns the pin; idle line is high
  assign rxd_in = rxd_oe ? rxd_out : drv;
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      drv <= f[i];
      repeat (per) @(posedge hclk);
    end
    drv <= 1'b1;
  endtask
  // Shift partner: next bit on each falling shift clock
  task automatic shift_in(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_out);
      drv <= b[i];
    end
    // Hold the last bit until it has been sampled
    @(posedge txd_out);
    drv <= 1'b1;
  endtask
endmodule // su_remote_model

// ---- sim/serial_usart_with_baud_gen_tb_top.sv ----
/*
  Testbench of the serial port: registers, all modes, interrupt.
  Assumes the checker is bound and the remote model drives rxd_in.
*/
module serial_usart_with_baud_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import su_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic t1_ovf = 1'b0;
  logic [1:0] ovf_q = 2'h0, htrans = 2'h0;
  logic [7:0] haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, rd_s, r, hrdata;
  logic hreadyout, hresp, rxd_in, rxd_out, rxd_oe, txd_out, irq;
  int fail_count = 0, num_checks = 0, cyc = 0;
  always #50 hclk = ~hclk;
  always @(negedge hclk) rd_s = hrdata;
  // Timer 1 overflow every fourth cycle
  always @(posedge hclk) begin
    ovf_q <= ovf_q + 2'h1;
    t1_ovf <= (ovf_q == 2'h3);
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  su_serial_port DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .t1_ovf(t1_ovf), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
  su_remote_model MDL (.hclk(hclk), .rxd_oe(rxd_oe), .rxd_out(rxd_out),
    .txd_out(txd_out), .rxd_in(rxd_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= SU_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = rd_s;
  endtask
  task automatic wait_txd(input logic v);
    int k;
    k = 0;
    while (txd_out !== v && k < 300) begin
      @(negedge hclk);
      k++;
    end
    if (k == 300) chk(32'h1, 32'h0);
  endtask
  task automatic poll(input logic [31:0] m);
    for (int k = 0; k < 40 && (r & m) == 32'h0; k++)
      bus(SU_OFS_STATUS, 1'b0, 32'h0);
  endtask
  task automatic irq_after(input logic [7:0] a, input logic [31:0] d,
                           input logic e);
    bus(a, 1'b1, d);
    repeat (2) @(negedge hclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic tx_chk(input logic [7:0] c, d, input int n, per);
    logic [10:0] f;
    f = (n == 10) ? {2'b11, d, 1'b0} : {1'b1, c[5], d, 1'b0};
    bus(SU_OFS_CTRL, 1'b1, {24'h0, c});
    bus(SU_OFS_TXDATA, 1'b1, {24'h0, d});
    wait_txd(1'b0);
    repeat (per / 2) @(negedge hclk);
    for (int i = 0; i < n; i++) begin
      chk({31'h0, txd_out}, {31'h0, f[i]});
      repeat (per) @(negedge hclk);
    end
    $display("tx mode %0d done", c[1:0]);
  endtask
  task automatic t_regs;
    bus(SU_OFS_CTRL, 1'b0, 32'h0);
    chk(r, {26'h0, SU_CTRL_RESET});
    bus(SU_OFS_INT_EN, 1'b0, 32'h0);
    chk(r, {30'h0, SU_IRQ_EN_RESET});
    bus(SU_OFS_STATUS, 1'b0, 32'h0);
    chk(r, 32'h0);
    bus(8'h20, 1'b1, 32'hffffffff);
    bus(8'h20, 1'b0, 32'h0);
    chk(r, 32'h0);
    bus(SU_OFS_CTRL, 1'b1, 32'hffffffff);
    bus(SU_OFS_CTRL, 1'b0, 32'h0);
    chk(r, 32'h3f);
    $display("registers done");
  endtask
  task automatic t_duplex;
    fork
      tx_chk(8'h3a, 8'h96, 11, 32);
      begin
        repeat (12) @(posedge hclk);
        MDL.send({2'b11, 8'h4b, 1'b0}, 11, 32);
      end
    join
    r = 32'h0;
    poll(32'h1);
    bus(SU_OFS_RXDATA, 1'b0, 32'h0);
    chk(r, 32'h14b);
    bus(SU_OFS_STATUS, 1'b0, 32'h0);
    chk(r & 32'h3, 32'h3);
    @(negedge hclk);
    chk({31'h0, irq}, 32'h0);
    irq_after(SU_OFS_INT_EN, 32'h2, 1'b1);
    irq_after(SU_OFS_INT_CLR, 32'h2, 1'b0);
    irq_after(SU_OFS_INT_EN, 32'h3, 1'b1);
    irq_after(SU_OFS_INT_CLR, 32'h1, 1'b0);
    bus(SU_OFS_STATUS, 1'b0, 32'h0);
    chk(r & 32'h3, 32'h0);
    $display("duplex and interrupt done");
  endtask
  task automatic t_rx;
    // Mode 1 from timer 1, double rate: 64 cycles per bit
    bus(SU_OFS_CTRL, 1'b1, 32'h19);
    MDL.send({2'b11, 8'h3c, 1'b0}, 10, 64);
    r = 32'h0;
    poll(32'h1);
    bus(SU_OFS_RXDATA, 1'b0, 32'h0);
    chk(r, 32'h13c);
    bus(SU_OFS_INT_CLR, 1'b1, 32'h1);
    // Mode 0 receive starts as soon as it is enabled
    fork
      bus(SU_OFS_CTRL, 1'b1, 32'h10);
      MDL.shift_in(8'h6d);
    join
    r = 32'h0;
    poll(32'h1);
    bus(SU_OFS_RXDATA, 1'b0, 32'h0);
    chk(r, 32'h06d);
    $display("receive done");
  endtask
  task automatic t_shift;
    logic [7:0] sd = 8'ha5;
    bus(SU_OFS_CTRL, 1'b1, 32'h0);
    bus(SU_OFS_INT_CLR, 1'b1, 32'h3);
    bus(SU_OFS_TXDATA, 1'b1, {24'h0, sd});
    for (int i = 0; i < 8; i++) begin
      wait_txd(1'b0);
      wait_txd(1'b1);
      chk({31'h0, rxd_out}, {31'h0, sd[i]});
      chk({31'h0, rxd_oe}, 32'h1);
    end
    r = 32'h0;
    poll(32'h2);
    chk(r & 32'h3, 32'h2);
    @(negedge hclk);
    chk({31'h0, irq}, 32'h1);
    $display("shift mode done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    tx_chk(8'h0d, 8'h5a, 10, 1248);
    tx_chk(8'h22, 8'hc3, 11, 64);
    t_duplex;
    t_rx;
    tx_chk(8'h23, 8'h81, 11, 128);
    t_shift;
    tally_and_finish;
  end
endmodule // serial_usart_with_baud_gen_tb_top
